// ===== balance_pkg.sv
// Purpose: Shared constants and carriers for duty balance configuration
// Assumes: 100 MHz core clock, 8-bit register port
// Notes: Clamp limits expressed in core clock cycles
package balance_pkg;
	localparam logic [15:0] CFG_OFFSET = 16'hfe72;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam int VSEL_BIT = 7;
	localparam int VLIM_BIT = 6;
	localparam int VGAIN_HI = 5;
	localparam int VGAIN_LO = 4;
	localparam int CSEL_BIT = 3;
	localparam int CLIM_BIT = 2;
	localparam int CGAIN_HI = 1;
	localparam int CGAIN_LO = 0;
	localparam int CLK_PERIOD_NS = 10;
	localparam int WIDE_LIMIT_NS = 160;
	localparam int NARROW_LIMIT_NS = 80;
	localparam int WIDE_LIMIT_CYC = WIDE_LIMIT_NS / CLK_PERIOD_NS;
	localparam int NARROW_LIMIT_CYC = NARROW_LIMIT_NS / CLK_PERIOD_NS;
	localparam int CORR_W = 16;
	localparam int ERR_W = 12;

	typedef struct packed {
		logic [ERR_W-1:0] a;
		logic [ERR_W-1:0] b;
	} sense_pair_type;

	typedef struct packed {
		logic signed [CORR_W-1:0] volt_sec;
		logic signed [CORR_W-1:0] current;
	} correction_type;
endpackage : balance_pkg

// ===== interleave_balance_config.sv
// Purpose: Balance configuration register and bounded duty corrections
// Assumes: Inputs synchronous to clk_in; period_start_in marks cycle start
// Notes: Settings shadowed and applied only at switching boundaries
//
// Decided for this implementation: the strobed register port.

// Functional notes
// RQ1: Volt-second loop uses third channel when bit 7 clear, first when set.
// RQ2: Volt-second correction clamped to 160 ns, or 80 ns with bit 6 set.
// RQ3: Volt-second gain from bits 5:4: codes give 1, 4, 16, 64.
// RQ4: Current loop uses second sense pair when bit 3 clear, first when set.
// RQ5: Current correction clamped to 160 ns, or 80 ns with bit 2 set.
// RQ6: Current gain from bits 1:0: codes give 1, 4, 16, 64.
// RQ7: New settings take effect only at a switching-cycle boundary.
module interleave_balance_config (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic [15:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rdata_out,
	input wire logic period_start_in,
	input wire logic signed [balance_pkg::ERR_W-1:0] chan_a_err_in,
	input wire logic signed [balance_pkg::ERR_W-1:0] chan_c_err_in,
	input wire balance_pkg::sense_pair_type first_sense_in,
	input wire balance_pkg::sense_pair_type second_sense_in,
	output balance_pkg::correction_type corr_out,
	output logic [7:0] active_cfg_out
);
	import balance_pkg::*;

	logic rst_meta_q;
	logic rst_sync_q;
	logic [7:0] cfg_q;
	logic [7:0] act_q;
	logic [7:0] rdata_q;
	correction_type corr_q;
	correction_type corr_d;

	// Reset release through two flops
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	function automatic logic [3:0] gain_shift(input logic [1:0] code);
		// Gains are powers of four, so a shift is enough
		return {1'b0, code, 1'b0};
	endfunction

	function automatic logic signed [CORR_W-1:0] clamp(
			input logic signed [CORR_W+7:0] v, input logic narrow);
		logic signed [CORR_W+7:0] lim;
		lim = narrow ? (CORR_W+8)'(NARROW_LIMIT_CYC)
			: (CORR_W+8)'(WIDE_LIMIT_CYC);
		if (v > lim)
			return CORR_W'(lim);
		else if (v < -lim)
			return CORR_W'(-lim);
		else
			return CORR_W'(v);
	endfunction

	wire cfg_hit = addr_in == CFG_OFFSET;
	wire cfg_wr = wr_in && cfg_hit;
	wire cfg_rd = rd_in && cfg_hit;

	// Volt-second error: one channel error input taken as is, source per select bit
	wire logic signed [ERR_W-1:0] vs_err = act_q[VSEL_BIT] ? chan_a_err_in
		: chan_c_err_in; // RQ1
	wire sense_pair_type cb_pair = act_q[CSEL_BIT] ? first_sense_in
		: second_sense_in; // RQ4
	wire logic signed [ERR_W:0] cb_err = $signed({1'b0, cb_pair.a})
		- $signed({1'b0, cb_pair.b});
	wire logic signed [CORR_W+7:0] vs_raw = (CORR_W+8)'(vs_err)
		<<< gain_shift(act_q[VGAIN_HI:VGAIN_LO]); // RQ3
	wire logic signed [CORR_W+7:0] cb_raw = (CORR_W+8)'(cb_err)
		<<< gain_shift(act_q[CGAIN_HI:CGAIN_LO]); // RQ6

	// Field decode named once so the checks read like the register map
	wire vs_narrow = act_q[VLIM_BIT];
	wire cb_narrow = act_q[CLIM_BIT];
	wire logic [1:0] vs_code = act_q[VGAIN_HI:VGAIN_LO];
	wire logic [1:0] cb_code = act_q[CGAIN_HI:CGAIN_LO];

	always_comb begin
		corr_d.volt_sec = clamp(vs_raw, act_q[VLIM_BIT]); // RQ2
		corr_d.current = clamp(cb_raw, act_q[CLIM_BIT]); // RQ5
	end

	always_ff @(posedge clk_in or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			cfg_q <= CFG_RESET;
			act_q <= CFG_RESET;
			rdata_q <= 8'h00;
			corr_q <= '0;
		end else begin
			if (cfg_wr)
				cfg_q <= wdata_in;
			// Shadow copy avoids mixing settings mid-period
			if (period_start_in)
				act_q <= cfg_q; // RQ7
			rdata_q <= cfg_rd ? cfg_q : 8'h00;
			corr_q <= corr_d;
		end
	end

	assign rdata_out = rdata_q;
	assign corr_out = corr_q;
	assign active_cfg_out = act_q;

	a_boundary_only: assert property (@(posedge clk_in) disable iff (!rst_sync_q)
		!$past(period_start_in) |-> $stable(act_q)) // RQ7
		else $error("Active settings changed off boundary");
	a_vs_wide_clamp: assert property (@(posedge clk_in) disable iff (!rst_sync_q)
		!$past(act_q[6]) |-> corr_q.volt_sec <= 16 && corr_q.volt_sec >= -16) // RQ2
		else $error("Volt-second correction beyond wide limit");
	a_vs_narrow_clamp: assert property (@(posedge clk_in) disable iff (!rst_sync_q)
		$past(act_q[6]) |-> corr_q.volt_sec <= 8 && corr_q.volt_sec >= -8) // RQ2
		else $error("Volt-second correction beyond narrow limit");
	a_cb_wide_clamp: assert property (@(posedge clk_in) disable iff (!rst_sync_q)
		!$past(act_q[2]) |-> corr_q.current <= 16 && corr_q.current >= -16) // RQ5
		else $error("Current correction beyond wide limit");
	a_cb_narrow_clamp: assert property (@(posedge clk_in) disable iff (!rst_sync_q)
		$past(act_q[2]) |-> corr_q.current <= 8 && corr_q.current >= -8) // RQ5
		else $error("Current correction beyond narrow limit");
	// Sources carry different levels, so a swapped select shows at once
	a_vs_source_c: assert property (@(posedge clk_in) // RQ1
		disable iff (!rst_sync_q)
		!act_q[VSEL_BIT] && vs_narrow && vs_code == 2'h0
		&& chan_c_err_in == -12'sh002 |=> corr_q.volt_sec == -16'sh0002)
		else $error("Volt-second source not third channel");
	a_vs_source_a: assert property (@(posedge clk_in) // RQ1
		disable iff (!rst_sync_q)
		act_q[VSEL_BIT] && vs_narrow && vs_code == 2'h0
		&& chan_a_err_in == 12'sh003 |=> corr_q.volt_sec == 16'sh0003)
		else $error("Volt-second source not first channel");
	a_vs_gain_four: assert property (@(posedge clk_in) // RQ3
		disable iff (!rst_sync_q)
		!vs_narrow && vs_code == 2'h1 && vs_err == -12'sh002
		|=> corr_q.volt_sec == -16'sh0008)
		else $error("Volt-second gain code 01 not four");
	a_cb_gain_four: assert property (@(posedge clk_in) // RQ6
		disable iff (!rst_sync_q)
		!cb_narrow && cb_code == 2'h1 && cb_err == -13'sh0004
		|=> corr_q.current == -16'sh0010)
		else $error("Current gain code 01 not four");
	a_cb_pair_sel: assert property (@(posedge clk_in) // RQ4
		disable iff (!rst_sync_q)
		!act_q[CSEL_BIT] && cb_narrow && cb_code == 2'h0
		&& second_sense_in.a == 12'h005 && second_sense_in.b == 12'h009
		|=> corr_q.current == -16'sh0004)
		else $error("Current source not second pair");
	a_cb_pair_first: assert property (@(posedge clk_in) // RQ4
		disable iff (!rst_sync_q)
		act_q[CSEL_BIT] && cb_code == 2'h0
		&& first_sense_in.a == 12'h00a && first_sense_in.b == 12'h007
		|=> corr_q.current == 16'sh0003)
		else $error("Current source not first pair");

	// Code 00 gain checks stay inside the limit; code 10 and 11 checks expect the clamp limit
	a_vs_unity_gain: assert property (@(posedge clk_in) // RQ3
		disable iff (!rst_sync_q)
		vs_code == 2'h0 && vs_err == 12'sh003
		|=> corr_q.volt_sec == 16'sh0003)
		else $error("Volt-second gain code 00 not one");
	a_vs_gain_sixteen: assert property (@(posedge clk_in) // RQ3
		disable iff (!rst_sync_q)
		!vs_narrow && vs_code == 2'h2 && vs_err == 12'sh003
		|=> corr_q.volt_sec == 16'sh0010)
		else $error("Volt-second gain code 10 not saturating");
	a_vs_gain_max: assert property (@(posedge clk_in) // RQ3
		disable iff (!rst_sync_q)
		vs_narrow && vs_code == 2'h3 && vs_err == -12'sh002
		|=> corr_q.volt_sec == -16'sh0008)
		else $error("Volt-second gain code 11 not saturating");
	a_cb_unity_gain: assert property (@(posedge clk_in) // RQ6
		disable iff (!rst_sync_q)
		cb_code == 2'h0 && cb_err == 13'sh0003
		|=> corr_q.current == 16'sh0003)
		else $error("Current gain code 00 not one");
	a_cb_gain_sixteen: assert property (@(posedge clk_in) // RQ6
		disable iff (!rst_sync_q)
		cb_narrow && cb_code == 2'h2 && cb_err == -13'sh0004
		|=> corr_q.current == -16'sh0008)
		else $error("Current gain code 10 not saturating");
	a_cb_gain_max: assert property (@(posedge clk_in) // RQ6
		disable iff (!rst_sync_q)
		!cb_narrow && cb_code == 2'h3 && cb_err == 13'sh0003
		|=> corr_q.current == 16'sh0010)
		else $error("Current gain code 11 not saturating");

	// Saturation must land exactly on the limit, not merely inside it
	a_vs_wide_sat: assert property (@(posedge clk_in) // RQ2
		disable iff (!rst_sync_q)
		!vs_narrow && vs_code[1] && vs_err == 12'sh003
		|=> corr_q.volt_sec == 16'sh0010)
		else $error("Volt-second wide limit not reached");
	a_vs_narrow_sat: assert property (@(posedge clk_in) // RQ2
		disable iff (!rst_sync_q)
		vs_narrow && vs_code[1] && vs_err == -12'sh002
		|=> corr_q.volt_sec == -16'sh0008)
		else $error("Volt-second narrow limit not reached");
	a_cb_wide_sat: assert property (@(posedge clk_in) // RQ5
		disable iff (!rst_sync_q)
		!cb_narrow && cb_code[1] && cb_err == -13'sh0004
		|=> corr_q.current == -16'sh0010)
		else $error("Current wide limit not reached");
	a_cb_narrow_sat: assert property (@(posedge clk_in) // RQ5
		disable iff (!rst_sync_q)
		cb_narrow && cb_code != 2'h0 && cb_err == -13'sh0004
		|=> corr_q.current == -16'sh0008)
		else $error("Current narrow limit not reached");

	a_apply_boundary: assert property (@(posedge clk_in) // RQ7
		disable iff (!rst_sync_q)
		period_start_in |=> act_q == $past(cfg_q))
		else $error("Settings not applied at boundary");
	a_write_store: assert property (@(posedge clk_in)
		disable iff (!rst_sync_q)
		cfg_wr |=> cfg_q == $past(wdata_in))
		else $error("Register write not stored");
	a_cfg_hold: assert property (@(posedge clk_in)
		disable iff (!rst_sync_q)
		!cfg_wr |=> $stable(cfg_q))
		else $error("Register changed without write");
	a_read_idle: assert property (@(posedge clk_in)
		disable iff (!rst_sync_q)
		!cfg_rd |=> rdata_out == 8'h00)
		else $error("Read data not zero when idle");
	a_read_data: assert property (@(posedge clk_in) disable iff (!rst_sync_q)
		cfg_rd |=> rdata_out == $past(cfg_q))
		else $error("Read data mismatch");

	c_write_cfg: cover property (@(posedge clk_in) cfg_wr ##[1:20] period_start_in);
	c_vs_clamped: cover property (@(posedge clk_in) corr_q.volt_sec == 16'sd16);
	c_cb_narrow: cover property (@(posedge clk_in) act_q[2] && corr_q.current == -16'sd8);
	c_cb_gain_max: cover property (@(posedge clk_in)
		cb_code == 2'h3 && corr_q.current == 16'sh0010);
	c_readback: cover property (@(posedge clk_in)
		cfg_rd ##1 rdata_out != 8'h00);
endmodule // interleave_balance_config

// ===== interleave_balance_config_tb.sv
// Purpose: Self-checking bench for duty balance configuration
// Assumes: Boundary pulse every 16 cycles from the engine model
// Notes: Expected corrections computed from fixed model error levels
module interleave_balance_config_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import balance_pkg::*;
	logic clk, resetn, wr, rd, ps;
	logic [15:0] addr;
	logic [7:0] wdata, rdata, act;
	logic signed [ERR_W-1:0] ea, ec;
	sense_pair_type s1, s2;
	correction_type corr;
	int fails = 0;
	int checks = 0;
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	pwm_engine_model u_eng (.clk_in(clk), .resetn_in(resetn),
		.period_start_out(ps), .chan_a_err_out(ea), .chan_c_err_out(ec),
		.first_sense_out(s1), .second_sense_out(s2));
	interleave_balance_config u_dut (.clk_in(clk), .resetn_in(resetn),
		.addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
		.rdata_out(rdata), .period_start_in(ps), .chan_a_err_in(ea),
		.chan_c_err_in(ec), .first_sense_in(s1), .second_sense_in(s2),
		.corr_out(corr), .active_cfg_out(act));
	task chk(string n, logic [15:0] e, logic [15:0] g);
		checks++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	task wr_reg(logic [15:0] a, logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rd_reg(logic [15:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task boundary;
		@(posedge clk iff ps === 1'b1);
		#1;
	endtask
	function automatic logic [15:0] clampv(int e, logic [2:0] f);
		int v;
		int m;
		v = e << (2 * f[1:0]);
		m = f[2] ? NARROW_LIMIT_CYC : WIDE_LIMIT_CYC;
		return 16'(v > m ? m : (v < -m ? -m : v));
	endfunction
	task test_register;
		logic [7:0] d;
		rd_reg(CFG_OFFSET, d);
		chk("reset", CFG_RESET, d);
		wr_reg(CFG_OFFSET, 8'ha5);
		wr_reg(16'hfe73, 8'h3c);
		rd_reg(16'hfe73, d);
		chk("unmapped", 16'h0000, d);
		rd_reg(CFG_OFFSET, d);
		chk("readback", 8'ha5, d);
		$display("test_register done");
	endtask
	task test_shadow;
		boundary;
		wr_reg(CFG_OFFSET, 8'h5a);
		chk("held", 8'ha5, act);
		boundary;
		chk("applied", 8'h5a, act);
		$display("test_shadow done");
	endtask
	task test_corr;
		logic [7:0] f;
		for (int i = 0; i < 16; i++) begin
			f = {i[3], i[2:0], i[3], i[2:0]};
			wr_reg(CFG_OFFSET, f);
			boundary;
			@(posedge clk);
			#1;
			chk("volt_sec", clampv(i[3] ? 3 : -2, f[6:4]), corr.volt_sec);
			chk("current", clampv(i[3] ? 3 : -4, f[2:0]), corr.current);
		end
		$display("test_corr done");
	endtask
	task end_of_test;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#50000;
		fails++;
		end_of_test;
	end
	initial begin
		{resetn, wr, rd, addr, wdata} = '0;
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		test_register;
		test_shadow;
		test_corr;
		end_of_test;
	end
endmodule // interleave_balance_config_tb

// ===== pwm_engine_model.sv
// Purpose: Model of PWM engine boundary pulse and sense inputs
// Assumes: Switching boundary every 16 core cycles
// Notes: Error levels fixed so high gains reach both clamp limits
module pwm_engine_model (
	input wire logic clk_in,
	input wire logic resetn_in,
	output logic period_start_out,
	output logic signed [balance_pkg::ERR_W-1:0] chan_a_err_out,
	output logic signed [balance_pkg::ERR_W-1:0] chan_c_err_out,
	output balance_pkg::sense_pair_type first_sense_out,
	output balance_pkg::sense_pair_type second_sense_out
);
	timeunit 1ns;
	timeprecision 1ns;
	import balance_pkg::*;
	logic [3:0] cnt_q;
	// Distinct signs per source expose a wrong selection
	assign chan_a_err_out = 12'h003;
	assign chan_c_err_out = 12'hffe;
	assign first_sense_out = '{a: 12'h00a, b: 12'h007};
	assign second_sense_out = '{a: 12'h005, b: 12'h009};
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cnt_q <= 4'h0;
			period_start_out <= 1'b0;
		end else begin
			cnt_q <= cnt_q + 4'h1;
			period_start_out <= (cnt_q == 4'hf);
		end
	end
endmodule // pwm_engine_model
